// [nps_host.sv]
// Overview of operation
// - At most 2 main, 3 spare partial programs.
// - Program: 80h, three addresses, data, 10h.
// - Erase: 60h, two block addresses, D0h.
// - Pass/fail valid only when ready.
// - Reissue 00h or 50h after status read; the host never does this itself, only the pointer op and the undefined ops 6 and 7 send it.
// - ID: 90h, address 00h, two reads.
// - Write-protect low inhibits program and erase.
`include "nps_regs.svh"
`default_nettype none
module nps_host (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic [3:0]      sw_addr,
    input  wire logic [31:0]     sw_wdata,
    input  wire logic            sw_wr,
    input  wire logic            sw_rd,
    output logic [31:0]          sw_rdata,
    output var nps_pkg::nps_ctl_t ctl,
    output logic [7:0]           io_out,
    output logic                 io_oe_n,
    input  wire logic [7:0]      io_in,
    input  wire logic            ready_busy_n
);
    typedef enum logic [3:0] {
        NPS_IDLE, NPS_CMD1, NPS_ADDR, NPS_DATA, NPS_CMD2,
        NPS_WAIT_BUSY, NPS_WAIT_READY, NPS_READS, NPS_DONE
    } nps_state_t;

    nps_state_t  st_ff, nxt_st;
    logic [2:0]  op_ff, nxt_op;
    logic [23:0] addr_ff, nxt_addr;
    logic [9:0]  len_ff, nxt_len;
    logic [9:0]  idx_ff, nxt_idx;
    logic [1:0]  acnt_ff, nxt_acnt;
    logic [7:0]  ptr_ff, nxt_ptr;
    logic        wp_n_ff, nxt_wp_n;
    logic [7:0]  stat_ff, nxt_stat;
    logic [7:0]  id0_ff, nxt_id0;
    logic [7:0]  id1_ff, nxt_id1;
    logic        err_ff, nxt_err;
    logic [1:0]  pcount_ff, nxt_pcount;
    logic [7:0]  page_mem [0:527];
    logic [7:0]  io_s1_ff, io_s2_ff;
    logic        rb_m1_ff, rb_ff;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        go, cyc_start, cyc_busy, cyc_done;
    nps_pkg::nps_cyc_t cyc_kind;
    logic [7:0]  cyc_wdata, cyc_rdata;
    logic        cle, ale, we_n, re_n;

    // The card pins are asynchronous to this clock, so both inputs are synchronised.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            io_s1_ff <= 8'h00;
            io_s2_ff <= 8'h00;
            rb_m1_ff <= 1'b1;
            rb_ff    <= 1'b1;
        end else begin
            io_s1_ff <= io_in;
            io_s2_ff <= io_s1_ff;
            rb_m1_ff <= ready_busy_n;
            rb_ff    <= rb_m1_ff;
        end
    end

    always_ff @(posedge clk) begin
        // A full buffer drops further bytes rather than writing past its end.
        if (sw_wr && sw_addr == `NPS_REG_DATA && st_ff == NPS_IDLE
            && idx_ff < `NPS_PAGE_BYTES) begin
            page_mem[idx_ff] <= sw_wdata[7:0];
        end
    end

    nps_bus_cycle u_cycle (
        .clk        (clk),
        .rst_b      (rst_b),
        .start      (cyc_start),
        .kind       (cyc_kind),
        .wdata      (cyc_wdata),
        .io_in_sync (io_s2_ff),
        .busy       (cyc_busy),
        .done       (cyc_done),
        .cle        (cle),
        .ale        (ale),
        .we_n       (we_n),
        .re_n       (re_n),
        .io_out     (io_out),
        .io_oe_n    (io_oe_n),
        .rdata      (cyc_rdata)
    );

    assign go = sw_wr && sw_addr == `NPS_REG_CTRL && sw_wdata[8];

    always_comb begin
        nxt_st     = st_ff;
        nxt_op     = op_ff;
        nxt_addr   = addr_ff;
        nxt_len    = len_ff;
        nxt_idx    = idx_ff;
        nxt_acnt   = acnt_ff;
        nxt_ptr    = ptr_ff;
        nxt_wp_n   = wp_n_ff;
        nxt_stat   = stat_ff;
        nxt_id0    = id0_ff;
        nxt_id1    = id1_ff;
        nxt_err    = err_ff;
        nxt_pcount = pcount_ff;
        nxt_rdata  = 32'h0000_0000;
        cyc_start  = 1'b0;
        cyc_kind   = nps_pkg::NPS_CYC_CMD;
        cyc_wdata  = 8'h00;
        if (sw_rd) begin
            unique case (sw_addr)
                `NPS_REG_CTRL:   nxt_rdata = {22'h0, wp_n_ff, 1'b0, ptr_ff};
                `NPS_REG_ADDR:   nxt_rdata = {8'h00, addr_ff};
                `NPS_REG_DATA:   nxt_rdata = {22'h0, len_ff};
                `NPS_REG_STATUS: nxt_rdata = {15'h0, pcount_ff, err_ff,
                                              st_ff != NPS_IDLE, 4'h0, rb_ff, stat_ff};
                `NPS_REG_RDATA:  nxt_rdata = {16'h0, id1_ff, id0_ff};
                default:         nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (sw_wr && st_ff == NPS_IDLE) begin
            unique case (sw_addr)
                `NPS_REG_CTRL: begin
                    nxt_wp_n = sw_wdata[9];
                    if (sw_wdata[10]) begin
                        nxt_pcount = 2'h0;
                    end
                end
                `NPS_REG_ADDR: nxt_addr = sw_wdata[23:0];
                `NPS_REG_DATA: begin
                    if (idx_ff < `NPS_PAGE_BYTES) begin
                        nxt_idx = idx_ff + 10'h1;
                    end
                    nxt_len = nxt_idx;
                end
                default: ;
            endcase
        end
        if (go && st_ff == NPS_IDLE) begin
            nxt_op  = sw_wdata[2:0];
            nxt_err = 1'b0;
            nxt_st  = NPS_CMD1;
            // A protected card would silently skip the cells, so refuse here.
            if ((sw_wdata[2:0] == `NPS_OP_PROGRAM || sw_wdata[2:0] == `NPS_OP_ERASE)
                && !wp_n_ff) begin
                nxt_err = 1'b1;
                nxt_st  = NPS_IDLE;
            end
            if (sw_wdata[2:0] == `NPS_OP_PROGRAM && (len_ff == 10'h0
                || pcount_ff == (ptr_ff == `NPS_CMD_READ_SPARE ?
                   `NPS_SPARE_PARTIAL : `NPS_MAIN_PARTIAL))) begin
                nxt_err = 1'b1;
                nxt_st  = NPS_IDLE;
            end
            if (sw_wdata[2:0] == `NPS_OP_POINTER) begin
                nxt_ptr = sw_wdata[23:16];
            end
        end
        unique case (st_ff)
            NPS_IDLE: ;
            NPS_CMD1: begin
                cyc_start = !cyc_busy && !cyc_done;
                unique case (op_ff)
                    `NPS_OP_PROGRAM: cyc_wdata = `NPS_CMD_SERIAL_IN;
                    `NPS_OP_ERASE:   cyc_wdata = `NPS_CMD_ERASE_SETUP;
                    `NPS_OP_STATUS:  cyc_wdata = `NPS_CMD_STATUS;
                    `NPS_OP_READ_ID: cyc_wdata = `NPS_CMD_READ_ID;
                    `NPS_OP_RESET:   cyc_wdata = `NPS_CMD_RESET;
                    default:         cyc_wdata = ptr_ff;
                endcase
                if (cyc_done) begin
                    nxt_acnt = 2'h0;
                    nxt_idx  = 10'h0;
                    unique case (op_ff)
                        `NPS_OP_PROGRAM, `NPS_OP_ERASE, `NPS_OP_READ_ID: nxt_st = NPS_ADDR;
                        `NPS_OP_STATUS: nxt_st = NPS_READS;
                        `NPS_OP_RESET:  nxt_st = NPS_WAIT_BUSY;
                        default:        nxt_st = NPS_DONE;
                    endcase
                end
            end
            NPS_ADDR: begin
                cyc_start = !cyc_busy && !cyc_done;
                cyc_kind  = nps_pkg::NPS_CYC_ADDR;
                if (op_ff == `NPS_OP_READ_ID) begin
                    cyc_wdata = `NPS_ID_ADDR;
                end else if (op_ff == `NPS_OP_ERASE) begin
                    cyc_wdata = acnt_ff[0] ? {1'b0, addr_ff[23:17]}
                                           : addr_ff[16:9];
                end else begin
                    unique case (acnt_ff)
                        2'h0:    cyc_wdata = addr_ff[7:0];
                        2'h1:    cyc_wdata = addr_ff[16:9];
                        default: cyc_wdata = addr_ff[23:17] == 7'h0 ?
                                             {1'b0, addr_ff[23:17]} : {1'b0, addr_ff[23:17]};
                    endcase
                end
                if (cyc_done) begin
                    nxt_acnt = acnt_ff + 2'h1;
                    if (op_ff == `NPS_OP_READ_ID) begin
                        nxt_st = NPS_READS;
                    end else if (op_ff == `NPS_OP_ERASE && acnt_ff == 2'h1) begin
                        nxt_st = NPS_CMD2;
                    end else if (op_ff == `NPS_OP_PROGRAM && acnt_ff == 2'h2) begin
                        nxt_st = NPS_DATA;
                    end
                end
            end
            NPS_DATA: begin
                cyc_start = !cyc_busy && !cyc_done;
                cyc_kind  = nps_pkg::NPS_CYC_WDATA;
                cyc_wdata = page_mem[idx_ff];
                if (cyc_done) begin
                    nxt_idx = idx_ff + 10'h1;
                    if (idx_ff + 10'h1 == len_ff) begin
                        nxt_st = NPS_CMD2;
                    end
                end
            end
            NPS_CMD2: begin
                cyc_start = !cyc_busy && !cyc_done;
                cyc_wdata = op_ff == `NPS_OP_ERASE ? `NPS_CMD_ERASE_CONF
                                                   : `NPS_CMD_PROG_CONF;
                if (cyc_done) begin
                    nxt_st = NPS_WAIT_BUSY;
                end
            end
            NPS_WAIT_BUSY: begin
                if (!rb_ff) begin
                    nxt_st = NPS_WAIT_READY;
                end
            end
            NPS_WAIT_READY: begin
                if (rb_ff) begin
                    nxt_st = op_ff == `NPS_OP_RESET ? NPS_DONE : NPS_CMD1;
                    nxt_op = op_ff == `NPS_OP_RESET ? op_ff : `NPS_OP_STATUS;
                    if (op_ff == `NPS_OP_PROGRAM) begin
                        nxt_pcount = pcount_ff + 2'h1;
                    end
                    if (op_ff == `NPS_OP_RESET) begin
                        nxt_ptr = `NPS_CMD_READ_MAIN;
                    end
                end
            end
            NPS_READS: begin
                cyc_start = !cyc_busy && !cyc_done;
                cyc_kind  = nps_pkg::NPS_CYC_RDATA;
                if (cyc_done) begin
                    nxt_acnt = acnt_ff + 2'h1;
                    if (op_ff == `NPS_OP_STATUS) begin
                        nxt_stat = cyc_rdata;
                        // Fail bit is trusted only once the card reports ready.
                        nxt_err  = cyc_rdata[`NPS_ST_READY_BIT]
                                   && cyc_rdata[`NPS_ST_FAIL_BIT];
                        nxt_st   = NPS_DONE;
                    end else if (acnt_ff == 2'h1) begin
                        nxt_id0 = cyc_rdata;
                    end else begin
                        nxt_id1 = cyc_rdata;
                        nxt_st  = NPS_DONE;
                    end
                end
            end
            NPS_DONE: begin
                nxt_st  = NPS_IDLE;
                nxt_idx = 10'h0;
            end
            default: nxt_st = NPS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff     <= NPS_IDLE;
            op_ff     <= `NPS_OP_STATUS;
            addr_ff   <= 24'h000000;
            len_ff    <= 10'h000;
            idx_ff    <= 10'h000;
            acnt_ff   <= 2'h0;
            ptr_ff    <= `NPS_CMD_READ_MAIN;
            wp_n_ff   <= 1'b0;
            stat_ff   <= `NPS_ST_RESET;
            id0_ff    <= 8'h00;
            id1_ff    <= 8'h00;
            err_ff    <= 1'b0;
            pcount_ff <= 2'h0;
            rdata_ff  <= 32'h0000_0000;
        end else begin
            st_ff     <= nxt_st;
            op_ff     <= nxt_op;
            addr_ff   <= nxt_addr;
            len_ff    <= nxt_len;
            idx_ff    <= nxt_idx;
            acnt_ff   <= nxt_acnt;
            ptr_ff    <= nxt_ptr;
            wp_n_ff   <= nxt_wp_n;
            stat_ff   <= nxt_stat;
            id0_ff    <= nxt_id0;
            id1_ff    <= nxt_id1;
            err_ff    <= nxt_err;
            pcount_ff <= nxt_pcount;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign sw_rdata          = rdata_ff;
    assign ctl               = '{cle: cle, ale: ale, we_n: we_n, read_strobe_n: re_n,
                                 ce_n: 1'b0, wp_n: wp_n_ff};

    AST_CMD_STROBE: assert property (@(posedge clk) disable iff (!rst_b)
        !we_n |-> (cle ^ ale) || !io_oe_n) else $error("strobe without latch");
    AST_NO_BOTH: assert property (@(posedge clk) disable iff (!rst_b)
        !(cle && ale)) else $error("both latches high");
    AST_WP_BLOCK: assert property (@(posedge clk) disable iff (!rst_b)
        (st_ff == NPS_CMD2) |-> wp_n_ff) else $error("program while protected");
    AST_LEN: assert property (@(posedge clk) disable iff (!rst_b)
        len_ff <= `NPS_PAGE_BYTES) else $error("page too long");
    AST_PCOUNT: assert property (@(posedge clk) disable iff (!rst_b)
        pcount_ff <= `NPS_SPARE_PARTIAL) else $error("partial count");
    AST_RDATA: assert property (@(posedge clk) disable iff (!rst_b)
        sw_rd && sw_addr == `NPS_REG_STATUS |=> sw_rdata[7:0] == $past(stat_ff))
        else $error("status readback");
    AST_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
        !re_n |-> io_oe_n) else $error("drive during read");
    AST_CONF: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(st_ff == NPS_WAIT_BUSY) && op_ff == `NPS_OP_PROGRAM |-> len_ff != 10'h0)
        else $error("lone confirm");
endmodule : nps_host
`default_nettype wire

// [nps_regs.svh]
`ifndef NPS_REGS_SVH
`define NPS_REGS_SVH
`define NPS_CMD_READ_MAIN   8'h00
`define NPS_CMD_READ_HALF2  8'h01
`define NPS_CMD_READ_SPARE  8'h50
`define NPS_CMD_SERIAL_IN   8'h80
`define NPS_CMD_PROG_CONF   8'h10
`define NPS_CMD_ERASE_SETUP 8'h60
`define NPS_CMD_ERASE_CONF  8'hD0
`define NPS_CMD_STATUS      8'h70
`define NPS_CMD_READ_ID     8'h90
`define NPS_CMD_RESET       8'hFF
`define NPS_ID_ADDR         8'h00
`define NPS_PAGE_BYTES      10'h210
`define NPS_MAIN_PARTIAL    2'h2
`define NPS_SPARE_PARTIAL   2'h3
`define NPS_ST_FAIL_BIT     0
`define NPS_ST_READY_BIT    6
`define NPS_ST_NWP_BIT      7
`define NPS_ST_RESET        8'hC0
`define NPS_REG_CTRL        4'h0
`define NPS_REG_ADDR        4'h1
`define NPS_REG_DATA        4'h2
`define NPS_REG_STATUS      4'h3
`define NPS_REG_RDATA       4'h4
`define NPS_OP_PROGRAM      3'h0
`define NPS_OP_ERASE        3'h1
`define NPS_OP_STATUS       3'h2
`define NPS_OP_READ_ID      3'h3
`define NPS_OP_RESET        3'h4
`define NPS_OP_POINTER      3'h5
`define NPS_PHASE_DIV       4'h4
`endif

// [nps_pkg.sv]
`default_nettype none
package nps_pkg;
    typedef enum logic [1:0] {
        NPS_CYC_CMD,
        NPS_CYC_ADDR,
        NPS_CYC_WDATA,
        NPS_CYC_RDATA
    } nps_cyc_t;
    typedef struct packed {
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic ce_n;
        logic wp_n;
    } nps_ctl_t;
endpackage : nps_pkg
`default_nettype wire

// [nps_bus_cycle.sv]
`include "nps_regs.svh"
`default_nettype none
// One strobed pin cycle: setup, strobe low, strobe high, done.
module nps_bus_cycle (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             start,
    input  wire nps_pkg::nps_cyc_t kind,
    input  wire logic [7:0]       wdata,
    input  wire logic [7:0]       io_in_sync,
    output logic                  busy,
    output logic                  done,
    output logic                  cle,
    output logic                  ale,
    output logic                  we_n,
    output logic                  re_n,
    output logic [7:0]            io_out,
    output logic                  io_oe_n,
    output logic [7:0]            rdata
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic       busy_ff, nxt_busy;
    nps_pkg::nps_cyc_t kind_ff, nxt_kind;
    logic [7:0] wd_ff, nxt_wd;
    logic [7:0] rd_ff, nxt_rd;
    logic       strobe_ff, nxt_strobe;
    logic       done_ff, nxt_done;

    always_comb begin
        nxt_cnt    = cnt_ff;
        nxt_busy   = busy_ff;
        nxt_kind   = kind_ff;
        nxt_wd     = wd_ff;
        nxt_rd     = rd_ff;
        nxt_strobe = strobe_ff;
        nxt_done   = 1'b0;
        if (!busy_ff) begin
            if (start) begin
                nxt_busy   = 1'b1;
                nxt_kind   = kind;
                nxt_wd     = wdata;
                nxt_cnt    = 4'h0;
                nxt_strobe = 1'b0;
            end
        end else begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == `NPS_PHASE_DIV - 4'h1) begin
                nxt_strobe = 1'b1;
            end
            if (cnt_ff == (`NPS_PHASE_DIV << 1) - 4'h1) begin
                nxt_strobe = 1'b0;
                if (kind_ff == nps_pkg::NPS_CYC_RDATA) begin
                    nxt_rd = io_in_sync;
                end
            end
            if (cnt_ff == (`NPS_PHASE_DIV * 4'h3) - 4'h1) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff    <= 4'h0;
            busy_ff   <= 1'b0;
            kind_ff   <= nps_pkg::NPS_CYC_CMD;
            wd_ff     <= 8'h00;
            rd_ff     <= 8'h00;
            strobe_ff <= 1'b0;
            done_ff   <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            busy_ff   <= nxt_busy;
            kind_ff   <= nxt_kind;
            wd_ff     <= nxt_wd;
            rd_ff     <= nxt_rd;
            strobe_ff <= nxt_strobe;
            done_ff   <= nxt_done;
        end
    end

    assign busy    = busy_ff;
    assign done    = done_ff;
    assign cle     = busy_ff && kind_ff == nps_pkg::NPS_CYC_CMD;
    assign ale     = busy_ff && kind_ff == nps_pkg::NPS_CYC_ADDR;
    assign we_n    = !(strobe_ff && kind_ff != nps_pkg::NPS_CYC_RDATA);
    assign re_n    = !(strobe_ff && kind_ff == nps_pkg::NPS_CYC_RDATA);
    assign io_out  = wd_ff;
    assign io_oe_n = !(busy_ff && kind_ff != nps_pkg::NPS_CYC_RDATA);
    assign rdata   = rd_ff;
endmodule : nps_bus_cycle
`default_nettype wire

// [nps_card_model.sv]
`default_nettype none
// Behavioural card: strobe driven, no clock; busy spans are shortened to keep runs brief.
module nps_card_model #(
    parameter logic [7:0] MAKER   = 8'h5A, // Arbitrary value.
    parameter logic [7:0] PART    = 8'hA5, // Arbitrary value.
    parameter int         BUSY_NS = 3000
) (
    input  wire nps_pkg::nps_ctl_t ctl,
    input  wire logic [7:0]        io_bus,
    output logic [7:0]             io_drv,
    output logic                   ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd_q[$];
    logic [7:0] addr_q[$];
    logic [7:0] data_q[$];
    int         mode = 0;
    int         id_idx = 0;
    int         n_load = 0;
    int         n_busy = 0;
    bit         loading = 0;
    bit         erase_arm = 0;
    bit         in_rst = 0;
    bit         ok;
    bit         start;
    task automatic go_busy(input bit is_rst);
        n_busy++;
        in_rst = is_rst;
        ready_busy_n = 1'b0;
        #(BUSY_NS);
        in_rst = 1'b0;
        ready_busy_n = 1'b1;
    endtask : go_busy
    initial ready_busy_n = 1'b1;
    initial io_drv = 8'h00;
    always @(posedge ctl.we_n) begin
        ok = ready_busy_n || io_bus == 8'h70 || (io_bus == 8'hFF && !in_rst);
        if (ctl.cle && ok) begin
            cmd_q.push_back(io_bus);
            start = (io_bus == 8'h10 && loading) || (io_bus == 8'hD0 && erase_arm);
            start = start && ctl.wp_n;
            if (start || io_bus == 8'h70) begin
                mode = 1;
            end else if (io_bus != 8'h10 && io_bus != 8'hD0) begin
                mode = io_bus == 8'h90 ? 2 : 0;
            end
            if (start || io_bus == 8'hFF) begin
                fork
                    go_busy(io_bus == 8'hFF);
                join_none
            end
            loading   = io_bus == 8'h80;
            erase_arm = io_bus == 8'h60;
            n_load    = 0;
            id_idx    = 0;
        end else if (ctl.ale) begin
            addr_q.push_back(io_bus);
        end else if (!ctl.cle && loading && n_load < 528) begin
            data_q.push_back(io_bus);
            n_load++;
        end
    end
    always @(negedge ctl.read_strobe_n) begin
        if (!ctl.ce_n && mode == 1) begin
            io_drv = {ctl.wp_n, ready_busy_n, 5'h00, 1'b0};
        end else if (!ctl.ce_n && mode == 2) begin
            io_drv = id_idx == 0 ? MAKER : PART;
            id_idx++;
        end
    end
    // A released bus keeps no value, so the inverse stops stale data passing for fresh.
    always @(posedge ctl.read_strobe_n) io_drv = ~io_drv;
endmodule : nps_card_model
`default_nettype wire

// [nps_host_tb.sv]
`include "nps_regs.svh"
`default_nettype none
module nps_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID_MAKER = 8'h5A; // Arbitrary value.
    localparam logic [7:0] ID_PART  = 8'hA5; // Arbitrary value.
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [3:0]        sw_addr = 4'h0;
    logic [31:0]       sw_wdata = 32'h0;
    logic              sw_wr = 1'b0;
    logic              sw_rd = 1'b0;
    logic [31:0]       sw_rdata;
    nps_pkg::nps_ctl_t ctl;
    logic [7:0]        h_io;
    logic [7:0]        d_io;
    logic [7:0]        io_bus;
    logic              io_oe_n;
    logic              ready_busy_n;
    logic [31:0]       rd_val;
    int                num_errors = 0;
    int                n_compared = 0;
    int                c0;
    int                b0;
    assign io_bus = io_oe_n ? d_io : h_io;
    always #5 clk = ~clk;
    nps_host DUT (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ctl(ctl), .io_out(h_io),
        .io_oe_n(io_oe_n), .io_in(io_bus), .ready_busy_n(ready_busy_n));
    nps_card_model #(.MAKER(ID_MAKER), .PART(ID_PART)) card (.ctl(ctl), .io_bus(io_bus),
        .io_drv(d_io), .ready_busy_n(ready_busy_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        d = sw_rdata;
    endtask : reg_rd
    // Polling is bounded so that a stuck engine shows up as a mismatch, not a hang.
    task automatic run_op(input logic [31:0] ctrl);
        c0 = card.cmd_q.size();
        b0 = card.n_busy;
        reg_wr(`NPS_REG_CTRL, ctrl);
        for (int i = 0; i < 4000; i++) begin
            reg_rd(`NPS_REG_STATUS, rd_val);
            if (rd_val[13] === 1'b0) break;
        end
        check(rd_val[13], 1'b0);
    endtask : run_op
    task automatic prog(input logic [7:0] x, input logic [7:0] y);
        reg_wr(`NPS_REG_DATA, {24'h0, x});
        reg_wr(`NPS_REG_DATA, {24'h0, y});
        reg_wr(`NPS_REG_ADDR, 32'h0012_3400);
        run_op(32'h0000_0300);
    endtask : prog
    task automatic t_protect();
        reg_wr(`NPS_REG_DATA, 32'h0000_005A);
        run_op(32'h0000_0100);
        check(rd_val[14], 1'b1);
        check(card.cmd_q.size() - c0, 0);
        $display("test protect done");
    endtask : t_protect
    task automatic t_program();
        // Protection is lifted in its own write, before any program is started.
        reg_wr(`NPS_REG_CTRL, 32'h0000_0600);
        prog(8'hA1, 8'hB2);
        check(card.cmd_q[c0], 8'h80);
        check(card.cmd_q[c0 + 1], 8'h10);
        check(card.cmd_q[c0 + 2], 8'h70);
        check(card.data_q[card.data_q.size() - 2], 8'hA1);
        check(card.data_q[$], 8'hB2);
        check(card.n_busy - b0, 1);
        check(rd_val[8:0], 9'h1C0);
        prog(8'h11, 8'h22);
        prog(8'h33, 8'h44);
        check(rd_val[14], 1'b1);
        check(card.n_busy - b0, 0);
        $display("test program done");
    endtask : t_program
    task automatic t_erase();
        reg_wr(`NPS_REG_ADDR, 32'h00AB_C000);
        run_op(32'h0000_0301);
        check(card.cmd_q[c0], 8'h60);
        check(card.cmd_q[c0 + 1], 8'hD0);
        check(card.addr_q[card.addr_q.size() - 2], 8'hE0);
        check(card.addr_q[$], 8'h55);
        check(card.n_busy - b0, 1);
        check(rd_val[7:0], 8'hC0);
        $display("test erase done");
    endtask : t_erase
    task automatic t_id();
        run_op(32'h0000_0303);
        check(card.cmd_q[c0], 8'h90);
        check(card.addr_q[$], 8'h00);
        reg_rd(`NPS_REG_RDATA, rd_val);
        check(rd_val[15:0], {ID_PART, ID_MAKER});
        $display("test id done");
    endtask : t_id
    task automatic t_status();
        run_op(32'h0000_0102);
        check(rd_val[7:0], 8'h40);
        run_op(32'h0000_0302);
        check(card.cmd_q[c0], 8'h70);
        check(rd_val[7:0], 8'hC0);
        $display("test status done");
    endtask : t_status
    task automatic t_reset_cmd();
        logic [7:0] codes[3] = '{`NPS_CMD_READ_SPARE, `NPS_CMD_READ_HALF2, `NPS_CMD_READ_MAIN};
        run_op(32'h0000_0304);
        check(card.cmd_q[c0], 8'hFF);
        check(card.n_busy - b0, 1);
        check(rd_val[8:0], 9'h1C0);
        run_op(32'h0000_0302);
        check(card.cmd_q[c0], 8'h70);
        check(rd_val[7:0], 8'hC0);
        foreach (codes[i]) begin
            run_op({8'h00, codes[i], 16'h0305});
            check(card.cmd_q[$], codes[i]);
        end
        $display("test reset and pointer done");
    endtask : t_reset_cmd
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge clk);
        check(ctl.wp_n, 1'b0);
        check(io_oe_n, 1'b1);
        rst_b <= 1'b1;
        t_protect();
        t_program();
        t_erase();
        t_id();
        t_status();
        t_reset_cmd();
        print_verdict();
    end
    initial begin
        #400_000;
        num_errors++;
        print_verdict();
    end
endmodule : nps_host_tb
`default_nettype wire
